// *** rtl/i2c_master_transaction_sequencer.sv ***
`default_nettype none
module i2c_master_transaction_sequencer
   import i2c_seq_pkg::*;
#(
   parameter int QTR = QTR_CYCLES
) (
   // System clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   // Link clock
   input  wire logic              i_link_clk,
   // Software control
   input  wire logic              i_controller_enable,
   input  wire logic              i_tx_irq_enable,
   input  wire logic              i_data_wr,
   input  wire logic [BYTE_W-1:0] i_data_wdata,
   input  wire logic              i_start_set,
   input  wire logic              i_stop_set,
   input  wire logic              i_flush,
   // Software status
   output logic                   o_tx_data_empty,
   output logic                   o_nack_irq_flag,
   output logic                   o_ack_status,
   output logic                   o_start_pending,
   output logic                   o_stop_pending,
   output logic                   o_tx_irq,
   output logic                   o_nack_irq,
   // Bus pins, open drain
   input  wire logic              i_scl,
   output logic                   o_scl_o,
   output logic                   o_scl_oe,
   input  wire logic              i_sda,
   output logic                   o_sda_o,
   output logic                   o_sda_oe
);

   if (QTR < 1 || QTR > (1 << QCNT_W)) begin : g_qtr_chk
      $error("QTR out of range for quarter counter");
   end

   // Last count of a quarter follows the instance's own QTR, not the default
   localparam logic [QCNT_W-1:0] QTR_END = QCNT_W'(QTR - 1);

   // ---------------- System domain ----------------
   logic [BYTE_W-1:0] data_ff;
   logic              full_ff;
   logic              start_ff;
   logic              stop_ff;
   logic              nack_ff;
   logic              ack_ff;
   logic [EV_NUM-1:0] ev_s1_ff;
   logic [EV_NUM-1:0] ev_s2_ff;
   logic [EV_NUM-1:0] ev_s3_ff;
   logic              ackv_s1_ff;
   logic              ackv_s2_ff;
   logic [EV_NUM-1:0] ev_pulse;

   // Link-domain signals
   logic [EV_NUM-1:0] tgl_ff;
   logic              ack_val_ff;

   // Toggle synchronisers for link events; first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ev_s1_ff   <= '0;
         ev_s2_ff   <= '0;
         ev_s3_ff   <= '0;
         ackv_s1_ff <= 1'b0;
         ackv_s2_ff <= 1'b0;
      end else begin
         ev_s1_ff   <= tgl_ff;
         ev_s2_ff   <= ev_s1_ff;
         ev_s3_ff   <= ev_s2_ff;
         ackv_s1_ff <= ack_val_ff;
         ackv_s2_ff <= ackv_s1_ff;
      end
   end

   assign ev_pulse = ev_s2_ff ^ ev_s3_ff;

   // Data register, loaded on every write, also while full
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         data_ff <= '0;
      end else if (i_data_wr) begin
         data_ff <= i_data_wdata;
      end
   end

   // Full flag: a write in the same cycle as the drain wins
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         full_ff <= 1'b0;
      end else if (i_data_wr) begin
         full_ff <= 1'b1;
      end else if (i_flush || ev_pulse[EV_FIRST]) begin
         full_ff <= 1'b0;
      end
   end

   // Start and stop stay set until the condition is on the bus
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         start_ff <= 1'b0;
         stop_ff  <= 1'b0;
      end else begin
         if (i_start_set) begin
            start_ff <= 1'b1;
         end else if (ev_pulse[EV_START]) begin
            start_ff <= 1'b0;
         end
         if (i_stop_set) begin
            stop_ff <= 1'b1;
         end else if (ev_pulse[EV_STOP]) begin
            stop_ff <= 1'b0;
         end
      end
   end

   // Nack flag and acknowledge status
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         nack_ff <= 1'b0;
         ack_ff  <= 1'b0;
      end else begin
         if (ev_pulse[EV_NACK]) begin
            nack_ff <= 1'b1;
         end else if (ev_pulse[EV_STOP] || ev_pulse[EV_START]) begin
            nack_ff <= 1'b0;
         end
         if (ev_pulse[EV_ACK]) begin
            ack_ff <= ackv_s2_ff;
         end
      end
   end

   // Status outputs from registers; interrupts gated by the enables
   assign o_tx_data_empty = ~full_ff;
   assign o_nack_irq_flag = nack_ff;
   assign o_ack_status    = ack_ff;
   assign o_start_pending = start_ff;
   assign o_stop_pending  = stop_ff;
   assign o_tx_irq        = i_controller_enable & i_tx_irq_enable & ~full_ff;
   assign o_nack_irq      = i_controller_enable & nack_ff;

   // ---------------- Link domain ----------------
   logic              lrst_s1_ff;
   logic              lrst_s2_ff;
   logic [LV_W-1:0]   lv_s1_ff;
   logic [LV_W-1:0]   lv_s2_ff;
   logic [LV_W-1:0]   lv_raw;
   link_state_type    state_ff;
   logic [QCNT_W-1:0] qcnt_ff;
   logic [1:0]        qtr_ff;
   logic [2:0]        bit_ff;
   logic [BYTE_W-1:0] shift_ff;
   logic              busy_ff;
   logic              scl_oe_ff;
   logic              sda_oe_ff;
   logic              nxt_scl_oe;
   logic              nxt_sda_oe;
   logic              en_s;
   logic              full_s;
   logic              start_s;
   logic              stop_s;
   logic              scl_s;
   logic              sda_s;
   logic [BYTE_W-1:0] data_s;
   logic              tick;
   logic              slot_end;
   logic              pending;

   // Reset brought into the link domain
   always_ff @(posedge i_link_clk) begin
      lrst_s1_ff <= i_rst_b;
      lrst_s2_ff <= lrst_s1_ff;
   end

   assign lv_raw = {data_ff, i_sda, i_scl, stop_ff, start_ff, full_ff,
                    i_controller_enable};

   // Levels and pins; data changes on any write, even while full reads set
   always_ff @(posedge i_link_clk) begin
      if (!lrst_s2_ff) begin
         lv_s1_ff <= '0;
         lv_s2_ff <= '0;
      end else begin
         lv_s1_ff <= lv_raw;
         lv_s2_ff <= lv_s1_ff;
      end
   end

   assign en_s    = lv_s2_ff[LV_EN];
   assign full_s  = lv_s2_ff[LV_FULL];
   assign start_s = lv_s2_ff[LV_START];
   assign stop_s  = lv_s2_ff[LV_STOP];
   assign scl_s   = lv_s2_ff[LV_SCL];
   assign sda_s   = lv_s2_ff[LV_SDA];
   assign data_s  = lv_s2_ff[LV_DATA +: BYTE_W];
   assign pending = start_s | stop_s;

   // Quarter timer; holds while a released SCL is still low (slave stretch)
   assign tick     = (qcnt_ff == QTR_END) && !(!scl_oe_ff && !scl_s);
   assign slot_end = tick && (qtr_ff == Q_LAST);

   always_ff @(posedge i_link_clk) begin
      if (!lrst_s2_ff) begin
         qcnt_ff <= '0;
         qtr_ff  <= Q_FIRST;
      end else if (tick) begin
         qcnt_ff <= '0;
         qtr_ff  <= qtr_ff + 2'h1;
      end else if (qcnt_ff != QTR_END) begin
         qcnt_ff <= qcnt_ff + QCNT_W'(1);
      end
   end

   // Transaction sequencer
   always_ff @(posedge i_link_clk) begin
      if (!lrst_s2_ff) begin
         state_ff   <= ST_IDLE;
         bit_ff     <= MSB_IDX;
         shift_ff   <= '0;
         busy_ff    <= 1'b0;
         ack_val_ff <= 1'b0;
      end else begin
         if (state_ff == ST_ACK && tick && qtr_ff == Q_SAMPLE) begin
            ack_val_ff <= ~sda_s;
         end
         if (slot_end) begin
            case (state_ff)
               ST_IDLE: begin
                  if (en_s && full_s && start_s) begin
                     state_ff <= ST_START;
                  end
               end
               ST_START: begin
                  busy_ff  <= 1'b1;
                  shift_ff <= data_s;
                  bit_ff   <= MSB_IDX;
                  state_ff <= ST_BIT;
               end
               ST_BIT: begin
                  if (bit_ff == LSB_IDX) begin
                     // Without a next byte or pending end, hold SCL low
                     state_ff <= (full_s || pending) ? ST_ACK : ST_WAIT;
                  end else begin
                     shift_ff <= {shift_ff[BYTE_W-2:0], 1'b0};
                     bit_ff   <= bit_ff - 3'h1;
                  end
               end
               ST_WAIT: begin
                  if (full_s || pending) begin
                     state_ff <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  if (stop_s) begin
                     state_ff <= ST_STOP;
                  end else if (start_s) begin
                     state_ff <= ST_START;
                  end else if (ack_val_ff) begin
                     shift_ff <= data_s;
                     bit_ff   <= MSB_IDX;
                     state_ff <= ST_BIT;
                  end else begin
                     state_ff <= ST_HOLD;
                  end
               end
               ST_HOLD: begin
                  if (stop_s) begin
                     state_ff <= ST_STOP;
                  end else if (start_s) begin
                     state_ff <= ST_START;
                  end
               end
               ST_STOP: begin
                  busy_ff  <= 1'b0;
                  state_ff <= ST_IDLE;
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Event toggles toward the system domain
   always_ff @(posedge i_link_clk) begin
      if (!lrst_s2_ff) begin
         tgl_ff <= '0;
      end else if (slot_end) begin
         if (state_ff == ST_BIT && bit_ff == MSB_IDX) begin
            tgl_ff[EV_FIRST] <= ~tgl_ff[EV_FIRST];
         end
         if (state_ff == ST_ACK) begin
            tgl_ff[EV_ACK] <= ~tgl_ff[EV_ACK];
         end
         if (state_ff == ST_ACK && !ack_val_ff && !pending) begin
            tgl_ff[EV_NACK] <= ~tgl_ff[EV_NACK];
         end
         if (state_ff == ST_START) begin
            tgl_ff[EV_START] <= ~tgl_ff[EV_START];
         end
         if (state_ff == ST_STOP) begin
            tgl_ff[EV_STOP] <= ~tgl_ff[EV_STOP];
         end
      end
   end

   // Pin drive per state and quarter; low half of a bit is quarters 0 and 1
   always_comb begin
      nxt_scl_oe = 1'b0;
      nxt_sda_oe = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
         end
         ST_START: begin
            // Repeated start first lets SDA rise while SCL is low
            nxt_scl_oe = busy_ff && (qtr_ff == Q_FIRST);
            nxt_sda_oe = (qtr_ff == Q_SAMPLE) || (qtr_ff == Q_LAST);
         end
         ST_BIT: begin
            nxt_scl_oe = (qtr_ff == Q_FIRST) || (qtr_ff == Q_SECOND);
            nxt_sda_oe = ~shift_ff[BYTE_W-1];
         end
         ST_WAIT, ST_HOLD: begin
            nxt_scl_oe = 1'b1;
            nxt_sda_oe = 1'b0;
         end
         ST_ACK: begin
            nxt_scl_oe = (qtr_ff == Q_FIRST) || (qtr_ff == Q_SECOND);
            nxt_sda_oe = 1'b0;
         end
         ST_STOP: begin
            nxt_scl_oe = (qtr_ff == Q_FIRST);
            nxt_sda_oe = (qtr_ff != Q_LAST);
         end
         default: begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
         end
      endcase
   end

   // Registered pin enables avoid glitches on the open-drain lines
   always_ff @(posedge i_link_clk) begin
      if (!lrst_s2_ff) begin
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else begin
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
      end
   end

   assign o_scl_oe = scl_oe_ff;
   assign o_sda_oe = sda_oe_ff;
   assign o_scl_o  = 1'b0;
   assign o_sda_o  = 1'b0;

endmodule : i2c_master_transaction_sequencer
`default_nettype wire

// *** common/i2c_seq_pkg.sv ***
// Function
// - Enabled empty data raises transmit interrupt
// - Start condition precedes any address bit
// - Load shifter per byte, send MSB first
// - Empty flag set after first address bit
// - Low SDA at ack sets ack status
// - Unpended nack sets flag, pauses bus
// - Stop after nack clears stop, flag
// - Transmit interrupt after each byte's first bit
// - Pending stop or start suppresses nack
// - Final byte ends in stop or restart
// - Stop bit reads set until sent
// - Probe leaves ack status as answer
// - Second 10-bit byte follows acked first
// - No start before data is loaded; a repeated start from ST_ACK or ST_HOLD does not wait for data
// - Stall before ack until data written
`default_nettype none
package i2c_seq_pkg;
   localparam int BYTE_W             = 8;
   localparam int LINK_CLK_PERIOD_NS = 15;
   localparam int SCL_QUARTER_NS     = 2500;
   // Least time, so round up
   localparam int QTR_CYCLES         = (SCL_QUARTER_NS + LINK_CLK_PERIOD_NS - 1)
                                       / LINK_CLK_PERIOD_NS;
   localparam int QCNT_W             = 8;
   localparam logic [1:0] Q_FIRST    = 2'h0;
   localparam logic [1:0] Q_SECOND   = 2'h1;
   localparam logic [1:0] Q_SAMPLE   = 2'h2;
   localparam logic [1:0] Q_LAST     = 2'h3;
   localparam logic [2:0] MSB_IDX    = 3'h7;
   localparam logic [2:0] LSB_IDX    = 3'h0;
   // Link-to-system event toggles
   localparam int EV_NUM   = 5;
   localparam int EV_FIRST = 0;
   localparam int EV_ACK   = 1;
   localparam int EV_NACK  = 2;
   localparam int EV_START = 3;
   localparam int EV_STOP  = 4;
   // System-to-link level vector layout
   localparam int LV_EN    = 0;
   localparam int LV_FULL  = 1;
   localparam int LV_START = 2;
   localparam int LV_STOP  = 3;
   localparam int LV_SCL   = 4;
   localparam int LV_SDA   = 5;
   localparam int LV_DATA  = 6;
   localparam int LV_W     = LV_DATA + BYTE_W;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_BIT,
      ST_WAIT,
      ST_ACK,
      ST_HOLD,
      ST_STOP
   } link_state_type;
endpackage : i2c_seq_pkg
`default_nettype wire

// *** dv/i2c_slave_model.sv ***
`default_nettype none
// Bus slave: watches both wires, pulls SDA low in the ninth clock when asked
module i2c_slave_model (
   // Resolved bus wires
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   // Answer control
   input  wire logic       i_ack_en,
   // Observations
   output logic            o_sda_oe,
   output logic [7:0]      o_byte,
   output int              o_nbytes,
   output int              o_nstops
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh;
   int         bits;
   initial begin
      o_sda_oe = 1'b0;
      o_byte   = 8'h00;
      o_nbytes = 0;
      o_nstops = 0;
      bits     = 0;
   end
   // Start or repeated start restarts the bit count
   always @(negedge i_sda) if (i_scl) bits = 0;
   always @(posedge i_sda) if (i_scl) o_nstops++;
   // Bits are taken on the rising clock, first bit is the MSB
   always @(posedge i_scl) begin
      if (bits < 8) begin
         sh = {sh[6:0], i_sda};
         bits++;
         if (bits == 8) begin
            o_byte = sh;
            o_nbytes++;
         end
      end
   end
   // Answer only after SCL falls, so the master's last bit is not disturbed
   always @(negedge i_scl) begin
      if (bits == 8) begin
         o_sda_oe = i_ack_en;
         bits     = 9;
      end else if (bits == 9) begin
         o_sda_oe = 1'b0;
         bits     = 0;
      end
   end
endmodule : i2c_slave_model
`default_nettype wire

// *** dv/i2c_master_transaction_sequencer_checker.sv ***
`default_nettype none
module i2c_master_transaction_sequencer_checker (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Software side
   input wire logic i_controller_enable,
   input wire logic i_tx_irq_enable,
   input wire logic i_data_wr,
   input wire logic i_start_set,
   input wire logic i_stop_set,
   input wire logic i_flush,
   input wire logic o_tx_data_empty,
   input wire logic o_nack_irq_flag,
   input wire logic o_ack_status,
   input wire logic o_start_pending,
   input wire logic o_stop_pending,
   input wire logic o_tx_irq,
   input wire logic o_nack_irq,
   // Bus side
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_scl_oe,
   input wire logic o_sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // Bus paused: SCL pulled low for a while
   sequence scl_held;
      o_scl_oe [*8];
   endsequence
   chk_tx_irq_gate: assert property (
      o_tx_irq == (i_controller_enable && i_tx_irq_enable && o_tx_data_empty))
      else $error("tx irq gating wrong");
   chk_nack_irq_gate: assert property (
      o_nack_irq == (i_controller_enable && o_nack_irq_flag)) else $error("nack irq wrong");
   chk_write_fills: assert property (
      i_data_wr |=> !o_tx_data_empty) else $error("write left empty");
   chk_flush_empties: assert property (
      i_flush && !i_data_wr |=> o_tx_data_empty) else $error("flush left full");
   chk_start_latch: assert property (
      i_start_set |=> o_start_pending) else $error("start not pending");
   chk_stop_latch: assert property (
      i_stop_set |=> o_stop_pending) else $error("stop not pending");
   chk_stop_done: assert property (
      $fell(o_stop_pending) |-> i_scl && i_sda) else $error("stop cleared early");
   chk_start_cause: assert property (
      $rose(o_sda_oe) && !o_scl_oe |-> o_start_pending) else $error("start unasked");
   chk_nack_idle: assert property (
      $rose(o_nack_irq_flag) |-> !o_stop_pending && !o_start_pending)
      else $error("nack with pending");
   chk_nack_ack: assert property (
      $rose(o_nack_irq_flag) |-> ##[0:3] !o_ack_status) else $error("ack kept on nack");
   chk_nack_pause: assert property (
      $rose(o_nack_irq_flag) |-> ##[0:12] scl_held) else $error("no pause on nack");
endmodule : i2c_master_transaction_sequencer_checker
`default_nettype wire

// *** dv/i2c_master_transaction_sequencer_test.sv ***
`default_nettype none
module i2c_master_transaction_sequencer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk = 0, lclk = 0, rst_b = 0, en = 1, tx_en = 1, ack_en = 1;
   logic       data_wr = 0, start_set = 0, stop_set = 0, flush = 0;
   logic [7:0] wdata = 8'h00;
   logic       empty, nflag, ack, spend, ppend, tx_irq_enable, nki, scl_oe, sda_oe, s_oe;
   logic [7:0] sbyte;
   int         nbytes, nstops, nst = 0, n0, fail_count = 0, checked = 0, cycles = 0;
   // Open drain with pull-ups
   wire        scl = !scl_oe;
   wire        sda = !(sda_oe || s_oe);
   initial forever #5 clk = !clk;
   initial forever #7.5 lclk = !lclk;
   i2c_master_transaction_sequencer #(.QTR(4)) u_i2c_master_transaction_sequencer (
      .i_clk(clk), .i_rst_b(rst_b), .i_link_clk(lclk), .i_controller_enable(en),
      .i_tx_irq_enable(tx_en), .i_data_wr(data_wr), .i_data_wdata(wdata),
      .i_start_set(start_set), .i_stop_set(stop_set), .i_flush(flush),
      .o_tx_data_empty(empty), .o_nack_irq_flag(nflag), .o_ack_status(ack),
      .o_start_pending(spend), .o_stop_pending(ppend), .o_tx_irq(tx_irq_enable), .o_nack_irq(nki),
      .i_scl(scl), .o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe));
   i2c_slave_model u_i2c_slave_model (.i_scl(scl), .i_sda(sda), .i_ack_en(ack_en),
      .o_sda_oe(s_oe), .o_byte(sbyte), .o_nbytes(nbytes), .o_nstops(nstops));
   task automatic stop_test;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One-cycle pulses of write, start, stop and flush
   task automatic ctl(input logic w, s, p, f, input logic [7:0] d);
      @(posedge clk) #1;
      {data_wr, start_set, stop_set, flush, wdata} = {w, s, p, f, d};
      @(posedge clk) #1;
      {data_wr, start_set, stop_set, flush} = 4'h0;
   endtask : ctl
   task automatic wait_stop;
      wait (ppend === 1'b0);
      #1;
      nst++;
   endtask : wait_stop
   task automatic probe(input logic [7:0] a, input logic ak);
      ack_en = ak;
      ctl(1, 0, 0, 0, a);
      tx_en = 0;
      ctl(0, 1, 1, 0, 8'h00);
      wait_stop();
      chk(spend, 0);
      chk(tx_irq_enable, 0);
      chk(ack, ak);
      chk(nflag, 0);
      chk(sbyte, a);
      chk(8'(nstops), 8'(nst));
   endtask : probe
   // Hang guard, a full run needs a few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_b = 1;
      repeat (8) @(posedge clk);
      // Unknown pins settling during reset may look like a stop to the slave
      nst = nstops;
      chk(tx_irq_enable, 1);
      probe(8'ha5, 0);
      probe(8'ha4, 1);
      // Write of three bytes, software late with the third
      tx_en = 1;
      n0 = nbytes;
      ctl(1, 0, 0, 0, 8'ha4);
      ctl(0, 1, 0, 0, 8'h00);
      wait (empty === 1'b1);
      chk(8'(nbytes), 8'(n0));
      ctl(1, 0, 0, 0, 8'h3c);
      wait (empty === 1'b1);
      repeat (300) @(posedge clk);
      chk(8'(nbytes), 8'(n0 + 2));
      chk(scl_oe, 1);
      ctl(1, 0, 0, 0, 8'hc3);
      wait (empty === 1'b1);
      #1 tx_en = 0;
      ctl(0, 0, 1, 0, 8'h00);
      wait_stop();
      chk(sbyte, 8'hc3);
      chk(ack, 1);
      chk(8'(nstops), 8'(nst));
      // Address refused while the next byte is already loaded
      tx_en = 1;
      ack_en = 0;
      ctl(1, 0, 0, 0, 8'ha4);
      ctl(0, 1, 0, 0, 8'h00);
      wait (empty === 1'b1);
      ctl(1, 0, 0, 0, 8'h77);
      wait (nflag === 1'b1);
      repeat (20) @(posedge clk);
      chk(nki, 1);
      chk(ack, 0);
      chk(scl_oe, 1);
      #1 tx_en = 0;
      ctl(0, 0, 1, 1, 8'h00);
      wait_stop();
      chk(nflag, 0);
      chk(empty, 1);
      chk(8'(nstops), 8'(nst));
      // Ten-bit address probe
      tx_en = 1;
      ack_en = 1;
      ctl(1, 0, 0, 0, 8'hf2);
      ctl(0, 1, 0, 0, 8'h00);
      wait (empty === 1'b1);
      ctl(1, 0, 0, 0, 8'h5a);
      wait (empty === 1'b1);
      chk(sbyte, 8'hf2);
      ctl(0, 0, 1, 0, 8'h00);
      wait_stop();
      chk(sbyte, 8'h5a);
      chk(ack, 1);
      stop_test();
   end
endmodule : i2c_master_transaction_sequencer_test
bind i2c_master_transaction_sequencer i2c_master_transaction_sequencer_checker u_chk (
   .i_clk, .i_rst_b, .i_controller_enable, .i_tx_irq_enable, .i_data_wr, .i_start_set,
   .i_stop_set, .i_flush, .o_tx_data_empty, .o_nack_irq_flag, .o_ack_status,
   .o_start_pending, .o_stop_pending, .o_tx_irq, .o_nack_irq, .i_scl, .i_sda,
   .o_scl_oe, .o_sda_oe);
`default_nettype wire
